// >>> core/boe_exec_core.sv
// How it works
// - Watchdog clear zeroes the watchdog counter
// - Watchdog clear zeroes prescaler, sets both flags
// - Accumulator call pushes PC plus one
// - In the same cycle PC gets upper latch and accumulator
// - Accumulator call: two cycles, flags untouched
// - Complement file to accumulator or file
// - Clear file writes zero, sets zero flag
// - Decrement file to accumulator or file
// - Clear accumulator writes zero, sets zero flag
// - Decrement-skip: skip next when result zero
`timescale 1ns/1ps
`default_nettype none
`include "boe_defs.svh"
module boe_exec_core (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  boe_pkg::boe_state_t state_reg;
  boe_pkg::boe_op_t op_reg;
  logic dest_reg;
  logic [6:0] addr_reg;
  logic [7:0] acc_reg;
  logic [14:0] pc_reg;
  logic [6:0] upper_reg;
  logic zero_reg, timeout_reg, pd_reg;
  logic [7:0] wdtPre_reg, wdtCount_reg;
  logic [7:0] fileMem [128];
  logic [14:0] stackMem [16];
  logic [3:0] stackPtr_reg;
  logic wrPend_reg;
  logic [11:0] wrAddr_reg;
  logic [31:0] rdata_next;
  logic [7:0] operand, decResult, fileWrData, accWrData;
  logic execWrFile, execWrAcc, inExec, swWr, wrIsFile, accept, twoCycle;
  logic [14:0] stackTop;

  // Bus acceptance of single word transfers
  assign accept = hsel && hready && htrans[1] && (hsize == 3'b010);
  assign swWr = wrPend_reg && (state_reg == boe_pkg::BOE_ST_IDLE);
  assign wrIsFile = (wrAddr_reg[11:9] == `BOE_FILE_BASE);
  assign inExec = (state_reg == boe_pkg::BOE_ST_EXEC);
  assign stackTop = stackMem[4'(stackPtr_reg - 4'h1)];

  // Operand fetch and results
  assign operand = fileMem[addr_reg];
  assign decResult = 8'(operand - 8'h01);
  assign twoCycle = (op_reg == boe_pkg::BOE_OP_CALL_VIA_ACC) ||
                    ((op_reg == boe_pkg::BOE_OP_DECREMENT_SKIP_ZERO) && (decResult == 8'h00));

  // Destination steering of results
  always_comb begin
    execWrFile = 1'b0;
    execWrAcc = 1'b0;
    fileWrData = decResult;
    accWrData = decResult;
    if (inExec) begin
      case (op_reg)
        boe_pkg::BOE_OP_COMPLEMENT_FILE: begin
          fileWrData = ~operand;
          accWrData = ~operand;
          execWrFile = dest_reg;
          execWrAcc = !dest_reg;
        end
        boe_pkg::BOE_OP_CLEAR_FILE: begin
          fileWrData = `BOE_FILE_RST;
          execWrFile = 1'b1;
        end
        boe_pkg::BOE_OP_DECREMENT_FILE, boe_pkg::BOE_OP_DECREMENT_SKIP_ZERO: begin
          execWrFile = dest_reg;
          execWrAcc = !dest_reg;
        end
        boe_pkg::BOE_OP_CLEAR_ACC: begin
          accWrData = `BOE_ACC_RST;
          execWrAcc = 1'b1;
        end
        default: execWrFile = 1'b0;
      endcase
    end
  end

  // Address phase capture for writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 12'h000;
    end else begin
      wrPend_reg <= accept && hwrite;
      wrAddr_reg <= haddr[11:0];
    end
  end

  // Read mux sampled in the address phase
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (haddr[11:9] == `BOE_FILE_BASE) begin
      rdata_next[7:0] = fileMem[haddr[8:2]];
    end else begin
      case (haddr[11:0])
        `BOE_CMD_OFS: rdata_next = {17'h0_0000, addr_reg, 4'h0, dest_reg, op_reg};
        `BOE_ACC_OFS: rdata_next[7:0] = acc_reg;
        `BOE_STATUS_OFS: rdata_next[3:0] = {state_reg != boe_pkg::BOE_ST_IDLE, pd_reg, timeout_reg, zero_reg};
        `BOE_PC_OFS: rdata_next[14:0] = pc_reg;
        `BOE_UPPER_OFS: rdata_next[6:0] = upper_reg;
        `BOE_STACK_OFS: rdata_next = {12'h000, stackPtr_reg, 1'b0, stackTop};
        `BOE_WDT_OFS: rdata_next[15:0] = {wdtCount_reg, wdtPre_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Bus response registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (accept && !hwrite) begin
        hrdata <= rdata_next;
      end
    end
  end

  // Command latch and sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= boe_pkg::BOE_ST_IDLE;
      op_reg <= boe_pkg::BOE_OP_NOP;
      dest_reg <= 1'b0;
      addr_reg <= 7'h00;
    end else begin
      case (state_reg)
        boe_pkg::BOE_ST_IDLE: begin
          if (swWr && (wrAddr_reg == `BOE_CMD_OFS)) begin
            op_reg <= boe_pkg::boe_op_t'(hwdata[`BOE_CMD_OP_LSB +: 3]);
            dest_reg <= hwdata[`BOE_CMD_DEST_BIT];
            addr_reg <= hwdata[`BOE_CMD_ADDR_LSB +: 7];
            state_reg <= boe_pkg::BOE_ST_EXEC;
          end
        end
        boe_pkg::BOE_ST_EXEC: begin
          state_reg <= twoCycle ? boe_pkg::BOE_ST_SECOND : boe_pkg::BOE_ST_IDLE;
        end
        boe_pkg::BOE_ST_SECOND: begin
          state_reg <= boe_pkg::BOE_ST_IDLE;
        end
        default: begin
          state_reg <= boe_pkg::BOE_ST_IDLE;
        end
      endcase
    end
  end

  // Accumulator
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_reg <= `BOE_ACC_RST;
    end else if (execWrAcc) begin
      acc_reg <= accWrData;
    end else if (swWr && (wrAddr_reg == `BOE_ACC_OFS)) begin
      acc_reg <= hwdata[7:0];
    end
  end

  // Program counter and upper latch
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pc_reg <= `BOE_PC_RST;
      upper_reg <= `BOE_UPPER_RST;
    end else begin
      if (inExec && (op_reg == boe_pkg::BOE_OP_CALL_VIA_ACC)) begin
        pc_reg <= {upper_reg, acc_reg};
      end else if (inExec) begin
        pc_reg <= 15'(pc_reg + 15'h0001);
      end else if ((state_reg == boe_pkg::BOE_ST_SECOND) &&
                   (op_reg == boe_pkg::BOE_OP_DECREMENT_SKIP_ZERO)) begin
        pc_reg <= 15'(pc_reg + 15'h0001);
      end else if (swWr && (wrAddr_reg == `BOE_PC_OFS)) begin
        pc_reg <= hwdata[14:0];
      end
      if (swWr && (wrAddr_reg == `BOE_UPPER_OFS)) begin
        upper_reg <= hwdata[6:0];
      end
    end
  end

  // Status flags
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      zero_reg <= `BOE_ZERO_RST;
      timeout_reg <= `BOE_TIMEOUT_RST;
      pd_reg <= `BOE_PD_RST;
    end else if (inExec && (op_reg == boe_pkg::BOE_OP_WATCHDOG_CLEAR)) begin
      timeout_reg <= 1'b1;
      pd_reg <= 1'b1;
    end else if (inExec && ((op_reg == boe_pkg::BOE_OP_CLEAR_FILE) || (op_reg == boe_pkg::BOE_OP_CLEAR_ACC))) begin
      zero_reg <= 1'b1;
    end else if (inExec && (op_reg == boe_pkg::BOE_OP_COMPLEMENT_FILE)) begin
      zero_reg <= (~operand == 8'h00);
    end else if (inExec && (op_reg == boe_pkg::BOE_OP_DECREMENT_FILE)) begin
      zero_reg <= (decResult == 8'h00);
    end else if (swWr && (wrAddr_reg == `BOE_STATUS_OFS)) begin
      zero_reg <= hwdata[`BOE_ST_ZERO_BIT];
      timeout_reg <= hwdata[`BOE_ST_TIMEOUT_BIT];
      pd_reg <= hwdata[`BOE_ST_PD_BIT];
    end else if ((wdtCount_reg == `BOE_WDT_MAX) && (wdtPre_reg == `BOE_WDT_MAX)) begin
      timeout_reg <= 1'b0;
    end
  end

  // Watchdog prescaler and counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wdtPre_reg <= `BOE_WDT_CLEAR;
      wdtCount_reg <= `BOE_WDT_CLEAR;
    end else if (inExec && (op_reg == boe_pkg::BOE_OP_WATCHDOG_CLEAR)) begin
      wdtPre_reg <= `BOE_WDT_CLEAR;
      wdtCount_reg <= `BOE_WDT_CLEAR;
    end else begin
      wdtPre_reg <= 8'(wdtPre_reg + 8'h01);
      if (wdtPre_reg == `BOE_WDT_MAX) begin
        wdtCount_reg <= 8'(wdtCount_reg + 8'h01);
      end
    end
  end

  // Return stack pointer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stackPtr_reg <= 4'h0;
    end else if (inExec && (op_reg == boe_pkg::BOE_OP_CALL_VIA_ACC)) begin
      stackPtr_reg <= 4'(stackPtr_reg + 4'h1);
    end
  end

  // Stack entries and file registers
  for (genvar i = 0; i < 16; i++) begin : gStack
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        stackMem[i] <= `BOE_PC_RST;
      end else if (inExec && (op_reg == boe_pkg::BOE_OP_CALL_VIA_ACC) && (stackPtr_reg == 4'(i))) begin
        stackMem[i] <= 15'(pc_reg + 15'h0001);
      end
    end
  end
  for (genvar i = 0; i < 128; i++) begin : gFile
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        fileMem[i] <= `BOE_FILE_RST;
      end else if (execWrFile && (addr_reg == 7'(i))) begin
        fileMem[i] <= fileWrData;
      end else if (swWr && wrIsFile && (wrAddr_reg[8:2] == 7'(i))) begin
        fileMem[i] <= hwdata[7:0];
      end
    end
  end

  // Checks next to the logic
  property p_wdtZero;
    @(posedge clk) disable iff (!nrst)
    (inExec && op_reg == boe_pkg::BOE_OP_WATCHDOG_CLEAR) |=> (wdtCount_reg == 8'h00);
  endproperty
  a_wdtZero: assert property (p_wdtZero) else $error("watchdog counter not cleared");
  property p_wdtFlags;
    @(posedge clk) disable iff (!nrst)
    (inExec && op_reg == boe_pkg::BOE_OP_WATCHDOG_CLEAR) |=> (wdtPre_reg == 8'h00) && timeout_reg && pd_reg;
  endproperty
  a_wdtFlags: assert property (p_wdtFlags) else $error("prescaler or flags wrong after clear");
  property p_callPush;
    @(posedge clk) disable iff (!nrst)
    (inExec && op_reg == boe_pkg::BOE_OP_CALL_VIA_ACC) |=> (stackTop == 15'($past(pc_reg) + 15'h0001));
  endproperty
  a_callPush: assert property (p_callPush) else $error("return address not pushed");
  property p_callTarget;
    @(posedge clk) disable iff (!nrst)
    (inExec && op_reg == boe_pkg::BOE_OP_CALL_VIA_ACC) |=> (pc_reg == {$past(upper_reg), $past(acc_reg)});
  endproperty
  a_callTarget: assert property (p_callTarget) else $error("call target wrong");
  property p_callTwo;
    @(posedge clk) disable iff (!nrst)
    (inExec && op_reg == boe_pkg::BOE_OP_CALL_VIA_ACC) |=>
      (state_reg == boe_pkg::BOE_ST_SECOND) && $stable(zero_reg) && $stable(pd_reg) ##1
      (state_reg == boe_pkg::BOE_ST_IDLE) && $stable(zero_reg);
  endproperty
  a_callTwo: assert property (p_callTwo) else $error("call length or flags wrong");
  property p_compAcc;
    @(posedge clk) disable iff (!nrst)
    (inExec && op_reg == boe_pkg::BOE_OP_COMPLEMENT_FILE && !dest_reg) |=> (acc_reg == ~$past(operand));
  endproperty
  a_compAcc: assert property (p_compAcc) else $error("complement result wrong");
  property p_clearFile;
    @(posedge clk) disable iff (!nrst)
    (inExec && op_reg == boe_pkg::BOE_OP_CLEAR_FILE) |=> (fileMem[$past(addr_reg)] == 8'h00) && zero_reg;
  endproperty
  a_clearFile: assert property (p_clearFile) else $error("clear file wrong");
  property p_decFile;
    @(posedge clk) disable iff (!nrst)
    (inExec && op_reg == boe_pkg::BOE_OP_DECREMENT_FILE && dest_reg) |=>
      (fileMem[$past(addr_reg)] == 8'($past(operand) - 8'h01));
  endproperty
  a_decFile: assert property (p_decFile) else $error("decrement result wrong");
  property p_clearAcc;
    @(posedge clk) disable iff (!nrst)
    (inExec && op_reg == boe_pkg::BOE_OP_CLEAR_ACC) |=> (acc_reg == 8'h00) && zero_reg;
  endproperty
  a_clearAcc: assert property (p_clearAcc) else $error("clear accumulator wrong");
  property p_skip;
    @(posedge clk) disable iff (!nrst)
    (inExec && op_reg == boe_pkg::BOE_OP_DECREMENT_SKIP_ZERO && decResult == 8'h00) |=>
      (state_reg == boe_pkg::BOE_ST_SECOND) ##1 (pc_reg == 15'($past(pc_reg, 2) + 15'h0002)) && $stable(zero_reg);
  endproperty
  a_skip: assert property (p_skip) else $error("skip not taken");
  property p_zeroUpd;
    @(posedge clk) disable iff (!nrst)
    (inExec && (op_reg == boe_pkg::BOE_OP_COMPLEMENT_FILE || op_reg == boe_pkg::BOE_OP_DECREMENT_FILE)) |=>
      (zero_reg == ($past(op_reg == boe_pkg::BOE_OP_COMPLEMENT_FILE) ? ($past(operand) == 8'hFF) :
                    ($past(operand) == 8'h01)));
  endproperty
  a_zeroUpd: assert property (p_zeroUpd) else $error("zero flag wrong");
  property p_single;
    @(posedge clk) disable iff (!nrst)
    (inExec && !twoCycle) |=> (state_reg == boe_pkg::BOE_ST_IDLE);
  endproperty
  a_single: assert property (p_single) else $error("single cycle form too long");
endmodule : boe_exec_core
`default_nettype wire

// >>> common/boe_defs.svh
`ifndef BOE_DEFS_SVH
`define BOE_DEFS_SVH
// Register byte offsets (haddr[11:0])
`define BOE_CMD_OFS 12'h000
`define BOE_ACC_OFS 12'h004
`define BOE_STATUS_OFS 12'h008
`define BOE_PC_OFS 12'h00C
`define BOE_UPPER_OFS 12'h010
`define BOE_STACK_OFS 12'h014
`define BOE_WDT_OFS 12'h018
// File window: haddr[11:9] equal to this, index in haddr[8:2]
`define BOE_FILE_BASE 3'h1
// Command field positions
`define BOE_CMD_OP_LSB 0
`define BOE_CMD_DEST_BIT 3
`define BOE_CMD_ADDR_LSB 8
// Status field positions
`define BOE_ST_ZERO_BIT 0
`define BOE_ST_TIMEOUT_BIT 1
`define BOE_ST_PD_BIT 2
`define BOE_ST_BUSY_BIT 3
// Reset values
`define BOE_ACC_RST 8'h00
`define BOE_PC_RST 15'h0000
`define BOE_UPPER_RST 7'h00
`define BOE_FILE_RST 8'h00
`define BOE_ZERO_RST 1'b0
`define BOE_TIMEOUT_RST 1'b1
`define BOE_PD_RST 1'b1
// Watchdog clear value and counter wrap
`define BOE_WDT_CLEAR 8'h00
`define BOE_WDT_MAX 8'hFF
`endif

// >>> common/boe_pkg.sv
`default_nettype none
package boe_pkg;
  typedef enum logic [2:0] {
    BOE_OP_WATCHDOG_CLEAR = 3'b000,
    BOE_OP_CALL_VIA_ACC = 3'b001,
    BOE_OP_COMPLEMENT_FILE = 3'b010,
    BOE_OP_CLEAR_FILE = 3'b011,
    BOE_OP_DECREMENT_FILE = 3'b100,
    BOE_OP_CLEAR_ACC = 3'b101,
    BOE_OP_DECREMENT_SKIP_ZERO = 3'b110,
    BOE_OP_NOP = 3'b111
  } boe_op_t;
  typedef enum logic [1:0] {
    BOE_ST_IDLE = 2'b00,
    BOE_ST_EXEC = 2'b01,
    BOE_ST_SECOND = 2'b10
  } boe_state_t;
endpackage : boe_pkg
`default_nettype wire

// >>> sim/boe_exec_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "boe_defs.svh"
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [31:0] hrdata;
  int fail_count = 0;
  int cmp_count = 0;
  // Reference model state
  logic [7:0] accM;
  logic [14:0] pcM;
  logic [6:0] upperM;
  logic [7:0] fileM [128];
  logic zeroM, toM, pdM;
  logic [14:0] stackM [16];
  logic [3:0] spM;

  // Clock, 25 ns period
  always #12.5 clk = ~clk;

  boe_exec_core dut_u (
    .clk(clk),
    .nrst(nrst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata)
  );

  // Verdict and end of run
  task end_sim;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One single-word transfer; entered just after a rising edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0_0000, a};
    hwrite <= wr;
    hsize <= 3'b010;
    @(posedge clk);
    // Address phase stands until the slave is ready; only the hang guard ends a hang
    while (hreadyout !== 1'b1) begin
      @(posedge clk);
    end
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      @(posedge clk);
    end
    rd = hrdata;
    check({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0000_0000, x);
    check(x, exp);
  endtask : rdc

  // Poll busy until the operation has finished
  task automatic wait_idle;
    logic [31:0] x;
    int n;
    for (n = 0; n < 20; n++) begin
      xfer(1'b0, `BOE_STATUS_OFS, 32'h0000_0000, x);
      if (x[`BOE_ST_BUSY_BIT] === 1'b0) break;
    end
    if (n >= 20) begin
      fail_count++;
      $display("ERROR t=%0t busy never cleared", $time);
    end
  endtask : wait_idle

  // Hang guard
  initial begin
    #(25 * 30000);
    fail_count++;
    $display("ERROR t=%0t timeout", $time);
    end_sim();
  end

  // Main sequence
  initial begin
    logic [2:0] op;
    logic dest;
    logic [6:0] fa;
    logic [7:0] r;
    logic [2:0] fl;
    logic [11:0] fAddr;
    logic [31:0] x;
    void'($urandom(69962));
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    accM = 8'h00;
    pcM = 15'h0000;
    upperM = 7'h00;
    zeroM = 1'b0;
    toM = 1'b1;
    pdM = 1'b1;
    spM = 4'h0;
    foreach (fileM[k]) fileM[k] = 8'h00;
    foreach (stackM[k]) stackM[k] = 15'h0000;
    // Bus response idles ready after reset
    check({31'h0000_0000, hreadyout}, 32'h0000_0001);
    // Reset values and an unmapped address
    rdc(`BOE_ACC_OFS, 32'h0000_0000);
    rdc(`BOE_PC_OFS, 32'h0000_0000);
    rdc(`BOE_UPPER_OFS, 32'h0000_0000);
    rdc(`BOE_STATUS_OFS, 32'h0000_0006);
    rdc(`BOE_STACK_OFS, 32'h0000_0000);
    rdc({`BOE_FILE_BASE, 7'h05, 2'b00}, 32'h0000_0000);
    wr(12'h100, 32'hFFFF_FFFF);
    rdc(12'h100, 32'h0000_0000);
    // Every operation against boundary and random operands
    for (int i = 0; i < 64; i++) begin
      op = i[2:0];
      // Each op meets every operand class with both destinations
      dest = i[3] ^ i[5];
      fa = 7'($urandom);
      fAddr = {`BOE_FILE_BASE, fa, 2'b00};
      case ((i / 8) % 4)
        0: fileM[fa] = 8'h01;
        1: fileM[fa] = 8'h00;
        2: fileM[fa] = 8'hFF;
        default: fileM[fa] = 8'($urandom);
      endcase
      accM = 8'($urandom);
      upperM = 7'($urandom);
      pcM = 15'($urandom);
      fl = 3'($urandom);
      {pdM, toM, zeroM} = fl;
      wr(fAddr, {24'h00_0000, fileM[fa]});
      wr(`BOE_ACC_OFS, {24'h00_0000, accM});
      wr(`BOE_UPPER_OFS, {25'h000_0000, upperM});
      wr(`BOE_PC_OFS, {17'h0_0000, pcM});
      wr(`BOE_STATUS_OFS, {29'h0000_0000, fl});
      wr(`BOE_CMD_OFS, {17'h0_0000, fa, 4'h0, dest, op});
      // Model of the operation
      case (op)
        3'd0: begin
          toM = 1'b1;
          pdM = 1'b1;
          pcM = pcM + 15'h0001;
        end
        3'd1: begin
          stackM[spM] = pcM + 15'h0001;
          spM = spM + 4'h1;
          pcM = {upperM, accM};
        end
        3'd2, 3'd4, 3'd6: begin
          r = (op == 3'd2) ? ~fileM[fa] : fileM[fa] - 8'h01;
          if (dest) fileM[fa] = r;
          else accM = r;
          if (op != 3'd6) zeroM = (r == 8'h00);
          pcM = pcM + ((op == 3'd6 && r == 8'h00) ? 15'h0002 : 15'h0001);
        end
        3'd3: begin
          fileM[fa] = 8'h00;
          zeroM = 1'b1;
          pcM = pcM + 15'h0001;
        end
        3'd5: begin
          accM = 8'h00;
          zeroM = 1'b1;
          pcM = pcM + 15'h0001;
        end
        default: pcM = pcM + 15'h0001;
      endcase
      wait_idle();
      if (op == 3'd0) begin
        xfer(1'b0, `BOE_WDT_OFS, 32'h0000_0000, x);
        check({24'h00_0000, x[15:8]}, 32'h0000_0000);
        check({31'h0000_0000, x[7:0] < 8'd64}, 32'h0000_0001);
      end
      rdc(`BOE_CMD_OFS, {17'h0_0000, fa, 4'h0, dest, op});
      rdc(`BOE_ACC_OFS, {24'h00_0000, accM});
      rdc(fAddr, {24'h00_0000, fileM[fa]});
      rdc(`BOE_STATUS_OFS, {28'h000_0000, 1'b0, pdM, toM, zeroM});
      rdc(`BOE_PC_OFS, {17'h0_0000, pcM});
      rdc(`BOE_STACK_OFS, {12'h000, spM, 1'b0, stackM[spM - 4'h1]});
    end
    end_sim();
  end
endmodule : testbench
`default_nettype wire
